// ### verilog/atfr_task_file.sv
// task-file register bank with status, control and interrupt logic
`timescale 1ns/10ps
module atfr_task_file
   import atfr_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic card_drive_num,
   input wire logic core_ready,
   input wire logic core_busy,
   input wire logic core_drq,
   input wire logic core_done,
   input wire logic core_fail,
   input wire logic [7:0] core_err_bits,
   input wire logic core_write_fault,
   input wire logic core_corrected,
   input wire logic [7:0] core_remaining,
   input wire logic core_addr_upd,
   input wire logic [27:0] core_fail_addr,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [7:0] feature_select,
   output logic [27:0] block_address,
   output logic lba_mode,
   output logic [3:0] head_number,
   output logic [8:0] sectors_to_move,
   output logic drive_selected,
   output logic soft_reset_active,
   output logic interrupt_request_line,
   output logic irq_enable_cfg
);
   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] err;
      logic [7:0] feat;
      logic [7:0] scnt;
      logic [7:0] snum;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] dh;
      logic [7:0] stat;
      logic srst;
      logic nien;
      logic irq;
      logic cmd_v;
      logic [7:0] cmd;
   } atfr_state_s;

   atfr_state_s st_ff;
   atfr_state_s nxt_st;
   logic busy;
   logic [7:0] status_view;
   logic [7:0] drv_addr_view;

   assign busy = st_ff.stat[ST_BSY_POS];
   // bit 7 reads as one, low bits carry inverted head and drive select
   assign drv_addr_view = {1'b1, ~core_busy, ~st_ff.dh[3:0],
                           ~(st_ff.dh[DH_DRV_POS] & card_drive_num),
                           ~(~st_ff.dh[DH_DRV_POS] & ~card_drive_num)};
   // soft reset forces the status byte to zero
   assign status_view = st_ff.srst ? BYTE_ZERO : st_ff.stat;

   // next-state logic for the whole bank
   always_comb begin
      nxt_st = st_ff;
      nxt_st.cmd_v = 1'b0;
      // live status; idx always zero
      nxt_st.stat[ST_BSY_POS] = core_busy;
      nxt_st.stat[ST_RDY_POS] = core_ready;
      nxt_st.stat[ST_DSC_POS] = core_ready;
      nxt_st.stat[1] = 1'b0;
      // host reads: only the primary status read acknowledges the irq
      if (reg_rd) begin
         case (reg_addr)
            OFS_ERR_FEAT: nxt_st.rdata = st_ff.err;
            OFS_SECT_CNT: nxt_st.rdata = st_ff.scnt;
            OFS_SECT_NUM: nxt_st.rdata = st_ff.snum;
            OFS_CYL_LOW: nxt_st.rdata = st_ff.cyl_lo;
            OFS_CYL_HIGH: nxt_st.rdata = st_ff.cyl_hi;
            OFS_DRV_HEAD: nxt_st.rdata = st_ff.dh;
            OFS_STAT_CMD: begin
               nxt_st.rdata = status_view;
               nxt_st.irq = 1'b0;
            end
            OFS_ALT_CTRL: nxt_st.rdata = status_view;
            OFS_DRV_ADDR: nxt_st.rdata = drv_addr_view;
            default: nxt_st.rdata = BYTE_ZERO;
         endcase
      end
      // host writes; task file locked while busy except control
      if (reg_wr && reg_addr == OFS_ALT_CTRL) begin
         nxt_st.srst = reg_wdata[DC_SRST_POS];
         nxt_st.nien = reg_wdata[DC_NIEN_POS];
      end else if (reg_wr && !busy && !st_ff.srst) begin
         case (reg_addr)
            OFS_ERR_FEAT: nxt_st.feat = reg_wdata;
            OFS_SECT_CNT: nxt_st.scnt = reg_wdata;
            OFS_SECT_NUM: nxt_st.snum = reg_wdata;
            OFS_CYL_LOW: nxt_st.cyl_lo = reg_wdata;
            OFS_CYL_HIGH: nxt_st.cyl_hi = reg_wdata;
            OFS_DRV_HEAD: nxt_st.dh = reg_wdata | DH_FIXED_ONES;
            OFS_STAT_CMD: begin
               nxt_st.cmd = reg_wdata;
               nxt_st.cmd_v = 1'b1;
               // a new command wipes the previous outcome
               nxt_st.stat[ST_DRQ_POS] = 1'b0;
               nxt_st.stat[ST_ERR_POS] = 1'b0;
               nxt_st.stat[ST_CORRECTED_DATA_FLAG_POS] = 1'b0;
               nxt_st.stat[ST_DWF_POS] = 1'b0;
               nxt_st.err = BYTE_ZERO;
            end
            default: nxt_st.cmd_v = 1'b0;
         endcase
      end
      // sticky flags come after the command clear so a same-cycle event is kept
      if (core_write_fault) begin
         nxt_st.stat[ST_DWF_POS] = 1'b1;
      end
      if (core_corrected) begin
         nxt_st.stat[ST_CORRECTED_DATA_FLAG_POS] = 1'b1;
      end
      if (core_drq) begin
         nxt_st.stat[ST_DRQ_POS] = 1'b1;
      end
      // command completion from the core
      if (core_done) begin
         if (core_fail) begin
            nxt_st.stat[ST_ERR_POS] = 1'b1;
            // only the defined error bits can stick
            nxt_st.err = core_err_bits & 8'hD5;
            nxt_st.scnt = core_remaining;
         end else begin
            nxt_st.scnt = BYTE_ZERO;
         end
         if (!st_ff.nien) begin
            nxt_st.irq = 1'b1;
         end
      end
      if (core_addr_upd) begin
         // failing sector left in the address registers
         nxt_st.snum = core_fail_addr[7:0];
         nxt_st.cyl_lo = core_fail_addr[15:8];
         nxt_st.cyl_hi = core_fail_addr[23:16];
         nxt_st.dh = {st_ff.dh[7:4], core_fail_addr[27:24]};
      end
      // soft reset: hold cleared, diagnostic code, defaults
      if (st_ff.srst) begin
         nxt_st.stat = BYTE_ZERO;
         nxt_st.err = DIAG_CODE_RST;
         nxt_st.scnt = SECT_CNT_RST;
         nxt_st.irq = 1'b0;
         nxt_st.cmd_v = 1'b0;
      end
   end

   // single state register, frozen while clk_en is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
         st_ff.scnt <= SECT_CNT_RST;
         st_ff.dh <= DH_FIXED_ONES;
         st_ff.nien <= 1'b0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // outputs from state flops; drive_selected also compares card_drive_num
   assign reg_rdata = st_ff.rdata;
   assign cmd_valid = st_ff.cmd_v;
   assign cmd_code = st_ff.cmd;
   assign feature_select = st_ff.feat;
   assign block_address = {st_ff.dh[3:0], st_ff.cyl_hi, st_ff.cyl_lo, st_ff.snum};
   assign lba_mode = st_ff.dh[DH_LBA_POS];
   assign head_number = st_ff.dh[3:0];
   // zero count requests the full 256
   assign sectors_to_move = (st_ff.scnt == BYTE_ZERO) ? 9'h100 : {1'b0, st_ff.scnt};
   assign drive_selected = (st_ff.dh[DH_DRV_POS] == card_drive_num);
   assign soft_reset_active = st_ff.srst;
   assign interrupt_request_line = st_ff.irq;
   assign irq_enable_cfg = ~st_ff.nien;

   AST_STAT_RD_CLR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_rd && reg_addr == OFS_STAT_CMD && !core_done |=> !interrupt_request_line)
      else $error("primary status read did not clear irq");
   AST_ALT_KEEP: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && interrupt_request_line && reg_rd && reg_addr == OFS_ALT_CTRL && !st_ff.srst
      |=> interrupt_request_line)
      else $error("alternate status read cleared irq");
   AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_done && st_ff.nien && !interrupt_request_line |=> !interrupt_request_line)
      else $error("irq raised while disabled");
   AST_IRQ_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_done && !st_ff.nien && !st_ff.srst |=> interrupt_request_line)
      else $error("completion irq missing");
   AST_SCNT_OK: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_done && !core_fail && !st_ff.srst |=> st_ff.scnt == 8'h00)
      else $error("sector count not zero after success");
   AST_SRST_STAT: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && st_ff.srst |=> st_ff.stat == 8'h00 && st_ff.err == DIAG_CODE_RST)
      else $error("soft reset state wrong");
   AST_DH_ONES: assert property (@(posedge clk) disable iff (!rstn)
      (st_ff.dh & DH_FIXED_ONES) == DH_FIXED_ONES)
      else $error("drive/head fixed bits lost");
   AST_CMD_CLR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && cmd_valid && !core_done |-> !st_ff.stat[ST_ERR_POS])
      else $error("error bit survives new command");
   AST_BUSY_LOCK: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && busy && reg_wr && reg_addr == OFS_SECT_NUM && !core_addr_upd
      |=> $stable(st_ff.snum))
      else $error("write accepted while busy");
   AST_IDX_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      !st_ff.stat[1])
      else $error("status bit 1 set");

   // register field checks, one per rule
   AST_ERR_RSVD: assert property (@(posedge clk) disable iff (!rstn)
      !st_ff.err[5] && !st_ff.err[3] && !st_ff.err[1])
      else $error("reserved error bit set");

   AST_ERR_RD: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_rd && reg_addr == OFS_ERR_FEAT |=> reg_rdata == $past(st_ff.err))
      else $error("error register read wrong");

   AST_FEAT_WR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == OFS_ERR_FEAT && !busy && !st_ff.srst
      |=> feature_select == $past(reg_wdata))
      else $error("feature write lost");

   AST_FEAT_NO_ERR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == OFS_ERR_FEAT && !core_done && !st_ff.srst
      |=> st_ff.err == $past(st_ff.err))
      else $error("feature write changed error register");

   AST_SCNT_256: assert property (@(posedge clk) disable iff (!rstn)
      st_ff.scnt == 8'h00 |-> sectors_to_move == 9'h100)
      else $error("zero count not 256");

   AST_SCNT_FAIL: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_done && core_fail && !st_ff.srst |=> st_ff.scnt == $past(core_remaining))
      else $error("remaining count not loaded");

   AST_SRST_SCNT: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && st_ff.srst |=> st_ff.scnt == SECT_CNT_RST)
      else $error("count default lost in soft reset");

   AST_LBA_ADDR: assert property (@(posedge clk) disable iff (!rstn)
      block_address == {head_number, st_ff.cyl_hi, st_ff.cyl_lo, st_ff.snum})
      else $error("block address assembly wrong");

   AST_LBA_SEL: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == OFS_DRV_HEAD && !busy && !st_ff.srst
      |=> lba_mode == $past(reg_wdata[DH_LBA_POS]))
      else $error("addressing mode bit lost");

   AST_DRV_ADDR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_rd && reg_addr == OFS_DRV_ADDR
      |=> reg_rdata[1] == !($past(st_ff.dh[DH_DRV_POS]) && $past(card_drive_num)))
      else $error("drive address select bit wrong");

   AST_DRV_HEADS: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_rd && reg_addr == OFS_DRV_ADDR |=> reg_rdata[5:2] == ~$past(st_ff.dh[3:0]))
      else $error("drive address head bits wrong");

   AST_ALT_SAME: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_rd && (reg_addr == OFS_STAT_CMD || reg_addr == OFS_ALT_CTRL)
      |=> reg_rdata == $past(status_view))
      else $error("status copies differ");

   AST_BUSY_MIRROR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en |=> $past(st_ff.srst) || busy == $past(core_busy))
      else $error("busy bit does not follow core");

   AST_RDY_MIRROR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en |=> $past(st_ff.srst) || st_ff.stat[ST_RDY_POS] == $past(core_ready))
      else $error("ready bit does not follow core");

   AST_DWF_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_write_fault && !st_ff.srst |=> st_ff.stat[ST_DWF_POS])
      else $error("write fault not flagged");

   AST_DSC_RDY: assert property (@(posedge clk) disable iff (!rstn)
      st_ff.stat[ST_DSC_POS] == st_ff.stat[ST_RDY_POS])
      else $error("seek complete differs from ready");

   AST_DRQ_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_drq && !st_ff.srst |=> st_ff.stat[ST_DRQ_POS])
      else $error("data request not flagged");

   AST_DRQ_CLR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == OFS_STAT_CMD && !busy && !st_ff.srst && !core_drq
      |=> !st_ff.stat[ST_DRQ_POS])
      else $error("data request survives command");

   AST_CMD_PULSE: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == OFS_STAT_CMD && !busy && !st_ff.srst
      |=> cmd_valid && cmd_code == $past(reg_wdata))
      else $error("command not passed on");

   AST_CORRECTED_DATA_FLAG_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_corrected && !st_ff.srst |=> st_ff.stat[ST_CORRECTED_DATA_FLAG_POS])
      else $error("corrected flag not set");

   AST_ERR_SET: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_done && core_fail && !st_ff.srst |=> st_ff.stat[ST_ERR_POS])
      else $error("error bit not set on failure");

   AST_FAIL_ADDR: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && core_addr_upd && !st_ff.srst |=> block_address == $past(core_fail_addr))
      else $error("failing sector not kept");

   AST_CTRL_BUSY: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && busy && reg_wr && reg_addr == OFS_ALT_CTRL
      |=> soft_reset_active == $past(reg_wdata[DC_SRST_POS]))
      else $error("control write refused while busy");

   AST_SRST_VIEW: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && st_ff.srst && reg_rd && reg_addr == OFS_STAT_CMD |=> reg_rdata == 8'h00)
      else $error("status not zero in soft reset");

   AST_IEN_CFG: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && reg_wr && reg_addr == OFS_ALT_CTRL
      |=> irq_enable_cfg == !$past(reg_wdata[DC_NIEN_POS]))
      else $error("interrupt enable copy wrong");

   AST_IRQ_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && interrupt_request_line && !(reg_rd && reg_addr == OFS_STAT_CMD)
      && !st_ff.srst |=> interrupt_request_line)
      else $error("irq dropped before status read");

   AST_DH_LOCK: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && busy && reg_wr && reg_addr == OFS_DRV_HEAD && !core_addr_upd
      |=> $stable(st_ff.dh))
      else $error("drive/head written while busy");

   AST_CYL_LOCK: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && busy && reg_wr && reg_addr == OFS_CYL_HIGH && !core_addr_upd
      |=> $stable(st_ff.cyl_hi))
      else $error("cylinder written while busy");

   AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      clk_en && !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
endmodule

// ### pkg/atfr_pkg.sv
// constants for the task-file register bank
package atfr_pkg;
   localparam logic [3:0] OFS_ERR_FEAT = 4'h1;
   localparam logic [3:0] OFS_SECT_CNT = 4'h2;
   localparam logic [3:0] OFS_SECT_NUM = 4'h3;
   localparam logic [3:0] OFS_CYL_LOW = 4'h4;
   localparam logic [3:0] OFS_CYL_HIGH = 4'h5;
   localparam logic [3:0] OFS_DRV_HEAD = 4'h6;
   localparam logic [3:0] OFS_STAT_CMD = 4'h7;
   localparam logic [3:0] OFS_ALT_CTRL = 4'hE;
   localparam logic [3:0] OFS_DRV_ADDR = 4'hF;
   // error register fields
   localparam int ERR_BBK_POS = 7;
   localparam int ERR_UNC_POS = 6;
   localparam int ERR_SECTOR_ID_MISSING_FLAG_POS = 4;
   localparam int ERR_COMMAND_ABORTED_FLAG_POS = 2;
   localparam int ERR_GEN_POS = 0;
   // drive/head fields
   localparam int DH_LBA_POS = 6;
   localparam int DH_DRV_POS = 4;
   localparam logic [7:0] DH_FIXED_ONES = 8'hA0;
   // status fields
   localparam int ST_BSY_POS = 7;
   localparam int ST_RDY_POS = 6;
   localparam int ST_DWF_POS = 5;
   localparam int ST_DSC_POS = 4;
   localparam int ST_DRQ_POS = 3;
   localparam int ST_CORRECTED_DATA_FLAG_POS = 2;
   localparam int ST_ERR_POS = 0;
   // device control fields
   localparam int DC_SRST_POS = 2;
   localparam int DC_NIEN_POS = 1;
   // reset values
   localparam logic [7:0] SECT_CNT_RST = 8'h01;
   localparam logic [7:0] DIAG_CODE_RST = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ### bench/atfr_host_model.sv
// host bus master model issuing byte accesses to the task file
`timescale 1ns/10ps
module atfr_host_model (
   input wire logic clk,
   output logic [3:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // idle bus at time zero
   initial begin
      reg_addr = 4'h0;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // one write, strobe held across exactly one rising edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = (a == 4'h6) ? (d | 8'hA0) : d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata; // released data never shows the last value
   endtask
   // one read, data registered at the taking edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the task-file register bank
`timescale 1ns/10ps
module tb;
   import atfr_pkg::*;
   logic clk, clk_en, rstn, reg_rd, reg_wr, card_drive_num, core_ready, core_busy, core_drq;
   logic core_done, core_fail, core_write_fault, core_corrected, core_addr_upd;
   logic cmd_valid, lba_mode, drive_selected, soft_reset_active;
   logic interrupt_request_line, irq_enable_cfg;
   logic [3:0] reg_addr, head_number;
   logic [7:0] reg_wdata, reg_rdata, core_err_bits, core_remaining, cmd_code;
   logic [7:0] feature_select, dh;
   logic [7:0] v [2:6];
   logic [8:0] sectors_to_move;
   logic [27:0] core_fail_addr, block_address;
   int n_mismatch = 0;
   int checks_done = 0;
   int seed;
   atfr_task_file dut_u (.clk, .rstn, .clk_en, .reg_addr, .reg_rd, .reg_wr,
      .reg_wdata, .reg_rdata, .card_drive_num, .core_ready, .core_busy, .core_drq,
      .core_done, .core_fail, .core_err_bits, .core_write_fault, .core_corrected,
      .core_remaining, .core_addr_upd, .core_fail_addr, .cmd_valid, .cmd_code,
      .feature_select, .block_address, .lba_mode, .head_number, .sectors_to_move,
      .drive_selected, .soft_reset_active, .interrupt_request_line, .irq_enable_cfg);
   atfr_host_model h_u (.clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata);
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_sig(input logic [27:0] got, input logic [27:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected signal at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // drive address byte: head bits and select bits inverted
   function automatic logic [7:0] drv_addr_exp(input logic [7:0] h, input logic c);
      return {1'b1, 1'b1, ~h[3:0], ~(h[4] & c), ~(~h[4] & ~c)};
   endfunction
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      h_u.rd(a, d);
      chk_byte(d, exp);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      stop_test;
   end
   initial begin
      seed = 32'h1DF4932F;
      clk_en = 1'b1;
      {rstn, card_drive_num, core_ready, core_busy, core_drq, core_done} = 6'h00;
      {core_fail, core_write_fault, core_corrected, core_addr_upd} = 4'h0;
      core_err_bits = 8'h00;
      core_remaining = 8'h00;
      core_fail_addr = 28'h0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      rdc(OFS_SECT_CNT, SECT_CNT_RST);
      rdc(OFS_STAT_CMD, BYTE_ZERO);
      chk_sig(28'(irq_enable_cfg), 28'h1);
      $display("reset test done");
      core_ready = 1'b1;
      // random task file contents, first pass with count zero
      for (int i = 0; i < 20; i++) begin
         card_drive_num = 1'($random(seed));
         for (int k = 2; k < 7; k++) begin
            v[k] = (i == 0) ? 8'h00 : 8'($random(seed));
            h_u.wr(4'(k), v[k]);
         end
         dh = v[6] | DH_FIXED_ONES;
         rdc(OFS_DRV_HEAD, dh);
         rdc(OFS_SECT_CNT, v[2]);
         chk_sig(block_address, {dh[3:0], v[5], v[4], v[3]});
         chk_sig(28'(head_number), 28'(dh[3:0]));
         chk_sig(28'(lba_mode), 28'(dh[6]));
         chk_sig(28'(sectors_to_move), (v[2] == 8'h00) ? 28'h100 : 28'(v[2]));
         chk_sig(28'(drive_selected), 28'(dh[4] == card_drive_num));
         rdc(OFS_DRV_ADDR, drv_addr_exp(dh, card_drive_num));
      end
      // clock enable low freezes the bank
      clk_en = 1'b0;
      h_u.wr(OFS_CYL_LOW, ~v[4]);
      clk_en = 1'b1;
      rdc(OFS_CYL_LOW, v[4]);
      h_u.wr(OFS_ERR_FEAT, 8'h5A);
      chk_sig(28'(feature_select), 28'h5A);
      rdc(OFS_ERR_FEAT, BYTE_ZERO);
      $display("register test done");
      // failing command with sticky flags and interrupt
      h_u.wr(OFS_STAT_CMD, 8'h20);
      chk_sig(28'({cmd_valid, cmd_code}), 28'h120);
      {core_drq, core_write_fault, core_corrected} = 3'h7;
      @(negedge clk);
      {core_drq, core_write_fault, core_corrected} = 3'h0;
      rdc(OFS_ALT_CTRL, 8'h7C);
      {core_err_bits, core_remaining, core_fail, core_done} = {8'hFF, 8'h05, 2'h3};
      @(negedge clk);
      core_done = 1'b0;
      chk_sig(28'(interrupt_request_line), 28'h1);
      rdc(OFS_ALT_CTRL, 8'h7D);
      rdc(OFS_ERR_FEAT, 8'hD5);
      rdc(OFS_SECT_CNT, 8'h05);
      chk_sig(28'(interrupt_request_line), 28'h1);
      rdc(OFS_STAT_CMD, 8'h7D);
      chk_sig(28'(interrupt_request_line), 28'h0);
      core_fail_addr = 28'($random(seed));
      core_addr_upd = 1'b1;
      @(negedge clk);
      core_addr_upd = 1'b0;
      chk_sig(block_address, core_fail_addr);
      rdc(OFS_SECT_NUM, core_fail_addr[7:0]);
      // next command clears, success leaves count zero
      h_u.wr(OFS_STAT_CMD, 8'hC4);
      rdc(OFS_ALT_CTRL, 8'h50);
      core_fail = 1'b0;
      core_done = 1'b1;
      @(negedge clk);
      core_done = 1'b0;
      rdc(OFS_SECT_CNT, BYTE_ZERO);
      $display("command test done");
      // busy refuses task file writes but not control
      core_busy = 1'b1;
      h_u.wr(OFS_SECT_CNT, 8'h33);
      rdc(OFS_SECT_CNT, BYTE_ZERO);
      rdc(OFS_ALT_CTRL, 8'hD0);
      rdc(OFS_STAT_CMD, 8'hD0);
      h_u.wr(OFS_ALT_CTRL, 8'h02);
      chk_sig(28'(irq_enable_cfg), 28'h0);
      core_done = 1'b1;
      @(negedge clk);
      core_done = 1'b0;
      chk_sig(28'(interrupt_request_line), 28'h0);
      h_u.wr(OFS_ALT_CTRL, 8'h04);
      chk_sig(28'(soft_reset_active), 28'h1);
      rdc(OFS_STAT_CMD, BYTE_ZERO);
      rdc(OFS_ERR_FEAT, DIAG_CODE_RST);
      core_busy = 1'b0;
      h_u.wr(OFS_ALT_CTRL, 8'h00);
      chk_sig(28'(soft_reset_active), 28'h0);
      $display("control test done");
      stop_test;
   end
endmodule
